// *** hw/adcsq_pkg.sv ***
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 8-bit register port, 4-bit register address
// Notes: offsets are register indexes on the plain port
package adcsq_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int RES_W = 10;
   // register offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_CLOCK_DIVIDER_SELECT = 4'h1;
   localparam logic [3:0] OFF_EVCTRL = 4'h2;
   localparam logic [3:0] OFF_COMMAND = 4'h3;
   localparam logic [3:0] OFF_INTEN = 4'h4;
   localparam logic [3:0] OFF_INTERRUPT_FLAGS_REG = 4'h5;
   localparam logic [3:0] OFF_RESLO = 4'h6;
   localparam logic [3:0] OFF_RESHI = 4'h7;
   localparam logic [3:0] OFF_INITDELAY = 4'h8;
   // field positions
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_FREERUN = 1;
   localparam int CTRL_RUNSTBY = 2;
   localparam int EV_START = 0;
   localparam int CMD_REQUEST = 0;
   localparam int CMD_INVALID = 1;
   localparam int FLAG_RESULT = 0;
   localparam int FLAG_WINDOW = 1;
   localparam int CLOCK_DIVIDER_SELECT_W = 3;
   // interrupt vector offsets
   localparam logic [7:0] VEC_RESULT = 8'h00;
   localparam logic [7:0] VEC_WINDOW = 8'h02;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] CLOCK_DIVIDER_SELECT_RST = 3'h0;
   localparam logic [7:0] INITDELAY_RST = 8'h00;
   // converter clock ticks per conversion
   localparam int CONV_TICKS = 11;
   localparam int CLOCK_DIVIDER_SELECT_CNT_W = 8;
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} adcsq_state_t;
endpackage : adcsq_pkg

// *** hw/adcsq_flag.sv ***
// Purpose: one sticky interrupt flag, write-one-to-clear
// Assumes: synchronous active-high reset
// Notes: a set in the clear cycle wins
`timescale 1ns/1ps
module adcsq_flag (
   // clock
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // control
   input wire logic setPulse,
   input wire logic clrPulse,
   output logic flag
);
   logic flag_reg;
   logic flag_next;

   always_comb begin
      flag_next = flag_reg;
      if (clrPulse) begin
         flag_next = 1'b0;
      end
      if (setPulse) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         flag_reg <= 1'b0;
      end else if (clkEn) begin
         flag_reg <= flag_next;
      end
   end

   assign flag = flag_reg;
endmodule : adcsq_flag

// *** hw/adcsq_prescaler.sv ***
// Purpose: converter clock prescaler, factor 2 << select
// Assumes: run low holds the counter at zero
// Notes: tick marks the converter clock rising edge
`timescale 1ns/1ps
module adcsq_prescaler #(
   parameter int CNT_W = adcsq_pkg::CLOCK_DIVIDER_SELECT_CNT_W
) (
   // clock
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // control
   input wire logic run,
   input wire logic hold,
   input wire logic [adcsq_pkg::CLOCK_DIVIDER_SELECT_W-1:0] divSelect,
   // status
   output logic tick,
   output logic [CNT_W-1:0] count
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W:0] factor;
   logic [CNT_W-1:0] lastCnt;
   logic [CNT_W-1:0] halfCnt;

   always_comb begin
      factor = (CNT_W+1)'(2) << divSelect;
      lastCnt = CNT_W'(factor - (CNT_W+1)'(1));
      halfCnt = CNT_W'((factor >> 1) - (CNT_W+1)'(1));
      cnt_next = cnt_reg;
      if (!run) begin
         cnt_next = '0;
      end else if (!hold) begin
         cnt_next = (cnt_reg == lastCnt) ? '0 : cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
      end else if (clkEn) begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick = run && !hold && (cnt_reg == halfCnt);
   assign count = cnt_reg;
endmodule : adcsq_prescaler

// *** hw/adcsq_top.sv ***
// Purpose: conversion sequencer for an analog-to-digital converter
// Assumes: plain register port, 8-bit data, inputs synchronous to sys_clk
// Notes: analog core delivers data and window hit at conversion end
`timescale 1ns/1ps
module adcsq_top #(
   parameter int CONV_TICKS = adcsq_pkg::CONV_TICKS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // register port
   input wire logic [adcsq_pkg::ADDR_W-1:0] regAddr,
   input wire logic [adcsq_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [adcsq_pkg::DATA_W-1:0] regRdData,
   // event and sleep
   input wire logic eventStart,
   input wire logic sleepStandby,
   input wire logic sleepPowerDown,
   // analog core
   input wire logic [adcsq_pkg::RES_W-1:0] adcData,
   input wire logic windowHit,
   output logic convBusy,
   // system
   output logic irq,
   output logic [7:0] irqVector,
   output logic clockRequest
);
   adcsq_pkg::adcsq_state_t state_reg, state_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [2:0] clock_divider_select_reg, clock_divider_select_next;
   logic evEn_reg, evEn_next;
   logic [1:0] intEn_reg, intEn_next;
   logic [7:0] initDelay_reg, initDelay_next;
   logic request_reg, request_next;
   logic invalid_reg, invalid_next;
   logic paused_reg, paused_next;
   logic evPrev_reg, evPrev_next;
   logic [adcsq_pkg::RES_W-1:0] result_reg, result_next;
   logic [7:0] delayCnt_reg, delayCnt_next;
   logic [7:0] tickCnt_reg, tickCnt_next;
   logic [7:0] rdData_reg, rdData_next;
   logic irq_reg, irq_next;
   logic [7:0] vec_reg, vec_next;
   logic clkReq_reg, clkReq_next;
   logic busy_reg, busy_next;
   logic [1:0] arm_reg, arm_next;
   logic enable, freeRun, active, evRise, swStart, trigger, done, tick;
   logic [1:0] flags;
   logic [7:0] prescCount;
   logic wrFlags;

   assign enable = ctrl_reg[adcsq_pkg::CTRL_ENABLE];
   assign freeRun = ctrl_reg[adcsq_pkg::CTRL_FREERUN];
   assign active = enable && !(sleepStandby && !ctrl_reg[adcsq_pkg::CTRL_RUNSTBY]);
   assign evRise = eventStart && !evPrev_reg;
   assign swStart = regWr && regAddr == adcsq_pkg::OFF_COMMAND
      && regWrData[adcsq_pkg::CMD_REQUEST];
   assign trigger = (swStart || (evEn_reg && evRise)) && active
      && !sleepPowerDown && !request_reg;
   assign done = state_reg == adcsq_pkg::ST_CONV && tick && active
      && tickCnt_reg == 8'(CONV_TICKS - 1);
   assign wrFlags = regWr && regAddr == adcsq_pkg::OFF_INTERRUPT_FLAGS_REG;

   // converter clock, run only while a request is pending
   adcsq_prescaler #(.CNT_W(adcsq_pkg::CLOCK_DIVIDER_SELECT_CNT_W)) uPresc (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .run(enable && request_reg && arm_reg[1]),
      .hold(sleepPowerDown),
      .divSelect(clock_divider_select_reg),
      .tick(tick),
      .count(prescCount)
   );

   // sticky flags
   adcsq_flag uFlagResult (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .setPulse(done),
      .clrPulse(wrFlags && regWrData[adcsq_pkg::FLAG_RESULT]),
      .flag(flags[adcsq_pkg::FLAG_RESULT])
   );
   adcsq_flag uFlagWindow (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .setPulse(done && windowHit),
      .clrPulse(wrFlags && regWrData[adcsq_pkg::FLAG_WINDOW]),
      .flag(flags[adcsq_pkg::FLAG_WINDOW])
   );

   // register writes
   always_comb begin
      ctrl_next = ctrl_reg;
      clock_divider_select_next = clock_divider_select_reg;
      evEn_next = evEn_reg;
      intEn_next = intEn_reg;
      initDelay_next = initDelay_reg;
      if (regWr) begin
         case (regAddr)
            adcsq_pkg::OFF_CTRL: ctrl_next = regWrData & 8'h07;
            adcsq_pkg::OFF_CLOCK_DIVIDER_SELECT: clock_divider_select_next = regWrData[2:0];
            adcsq_pkg::OFF_EVCTRL: evEn_next = regWrData[adcsq_pkg::EV_START];
            adcsq_pkg::OFF_INTEN: intEn_next = regWrData[1:0];
            adcsq_pkg::OFF_INITDELAY: initDelay_next = regWrData;
            default: ctrl_next = ctrl_reg;
         endcase
      end
   end

   // sequencer
   always_comb begin
      state_next = state_reg;
      request_next = request_reg;
      invalid_next = invalid_reg;
      paused_next = paused_reg;
      result_next = result_reg;
      delayCnt_next = delayCnt_reg;
      tickCnt_next = tickCnt_reg;
      evPrev_next = eventStart;
      if (!active) begin
         state_next = adcsq_pkg::ST_IDLE;
         request_next = 1'b0;
         paused_next = 1'b0;
      end else begin
         if (trigger) begin
            request_next = 1'b1;
         end
         if (sleepPowerDown && state_reg == adcsq_pkg::ST_CONV) begin
            paused_next = 1'b1;
         end
         case (state_reg)
            adcsq_pkg::ST_IDLE: begin
               if (request_reg && tick) begin
                  tickCnt_next = 8'h00;
                  delayCnt_next = initDelay_reg;
                  state_next = (initDelay_reg != 8'h00) ? adcsq_pkg::ST_DELAY
                     : adcsq_pkg::ST_CONV;
               end
            end
            adcsq_pkg::ST_DELAY: begin
               if (tick) begin
                  delayCnt_next = delayCnt_reg - 8'h01;
                  if (delayCnt_reg == 8'h01) begin
                     state_next = adcsq_pkg::ST_CONV;
                  end
               end
            end
            adcsq_pkg::ST_CONV: begin
               if (tick) begin
                  tickCnt_next = tickCnt_reg + 8'h01;
               end
               if (done) begin
                  result_next = adcData;
                  invalid_next = paused_reg || sleepPowerDown;
                  paused_next = 1'b0;
                  tickCnt_next = 8'h00;
                  if (!freeRun) begin
                     request_next = 1'b0;
                     state_next = adcsq_pkg::ST_IDLE;
                  end
               end
            end
            default: state_next = adcsq_pkg::ST_IDLE;
         endcase
      end
      // two-cycle arm before the prescaler runs, fixed start delay
      arm_next = request_next ? {arm_reg[0], request_reg} : 2'h0;
   end

   // outputs
   always_comb begin
      rdData_next = 8'h00;
      if (regRd) begin
         case (regAddr)
            adcsq_pkg::OFF_CTRL: rdData_next = ctrl_reg;
            adcsq_pkg::OFF_CLOCK_DIVIDER_SELECT: rdData_next = {5'h00, clock_divider_select_reg};
            adcsq_pkg::OFF_EVCTRL: rdData_next = {7'h00, evEn_reg};
            adcsq_pkg::OFF_COMMAND: rdData_next = {6'h00, invalid_reg, request_reg};
            adcsq_pkg::OFF_INTEN: rdData_next = {6'h00, intEn_reg};
            adcsq_pkg::OFF_INTERRUPT_FLAGS_REG: rdData_next = {6'h00, flags};
            adcsq_pkg::OFF_RESLO: rdData_next = result_reg[7:0];
            adcsq_pkg::OFF_RESHI: rdData_next = {6'h00, result_reg[9:8]};
            adcsq_pkg::OFF_INITDELAY: rdData_next = initDelay_reg;
            default: rdData_next = 8'h00;
         endcase
      end
      irq_next = |(flags & intEn_reg);
      vec_next = (flags[adcsq_pkg::FLAG_RESULT] && intEn_reg[adcsq_pkg::FLAG_RESULT])
         ? adcsq_pkg::VEC_RESULT : adcsq_pkg::VEC_WINDOW;
      clkReq_next = request_reg && active;
      busy_next = state_next == adcsq_pkg::ST_CONV;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= adcsq_pkg::ST_IDLE;
         ctrl_reg <= adcsq_pkg::CTRL_RST;
         clock_divider_select_reg <= adcsq_pkg::CLOCK_DIVIDER_SELECT_RST;
         evEn_reg <= 1'b0;
         intEn_reg <= 2'h0;
         initDelay_reg <= adcsq_pkg::INITDELAY_RST;
         request_reg <= 1'b0;
         invalid_reg <= 1'b0;
         paused_reg <= 1'b0;
         evPrev_reg <= 1'b0;
         result_reg <= '0;
         delayCnt_reg <= 8'h00;
         tickCnt_reg <= 8'h00;
         rdData_reg <= 8'h00;
         irq_reg <= 1'b0;
         vec_reg <= 8'h00;
         clkReq_reg <= 1'b0;
         busy_reg <= 1'b0;
         arm_reg <= 2'h0;
      end else if (clkEn) begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         clock_divider_select_reg <= clock_divider_select_next;
         evEn_reg <= evEn_next;
         intEn_reg <= intEn_next;
         initDelay_reg <= initDelay_next;
         request_reg <= request_next;
         invalid_reg <= invalid_next;
         paused_reg <= paused_next;
         evPrev_reg <= evPrev_next;
         result_reg <= result_next;
         delayCnt_reg <= delayCnt_next;
         tickCnt_reg <= tickCnt_next;
         rdData_reg <= rdData_next;
         irq_reg <= irq_next;
         vec_reg <= vec_next;
         clkReq_reg <= clkReq_next;
         busy_reg <= busy_next;
         arm_reg <= arm_next;
      end
   end

   assign regRdData = rdData_reg;
   assign irq = irq_reg;
   assign irqVector = vec_reg;
   assign clockRequest = clkReq_reg;
   assign convBusy = busy_reg;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_trigger;
      clkEn && trigger;
   endsequence
   sequence s_armed;
      request_reg && prescCount == 8'h00;
   endsequence

   a_flag_on_done: assert property (clkEn && done |=> flags[0])
      else $error("result ready not set at completion");
   a_event_start: assert property (clkEn && evEn_reg && evRise && active
      && !sleepPowerDown && !request_reg |=> request_reg)
      else $error("event did not start a conversion");
   a_req_clear: assert property (clkEn && done && !freeRun && active
      |=> !request_reg)
      else $error("request not cleared at completion");
   a_free_rerun: assert property (clkEn && done && freeRun && active
      |=> request_reg && state_reg == adcsq_pkg::ST_CONV)
      else $error("free run did not continue");
   a_clock_divider_select_idle: assert property (clkEn && !request_reg |=> prescCount == 8'h00)
      else $error("prescaler running while idle");
   a_start_delay: assert property (s_trigger ##1 s_armed |->
      ##[1:129] (tick && state_reg == adcsq_pkg::ST_IDLE))
      else $error("start edge late");
   a_irq_level: assert property (clkEn && (flags & intEn_reg) != 2'h0 |=> irq)
      else $error("interrupt not raised");
   a_irq_drop: assert property (clkEn && (flags & intEn_reg) == 2'h0 |=> !irq)
      else $error("interrupt raised without flag");
   a_standby_off: assert property (clkEn && enable && sleepStandby
      && !ctrl_reg[adcsq_pkg::CTRL_RUNSTBY] |=> !request_reg)
      else $error("converter active in standby");
   a_clock_release: assert property (clkEn && !request_reg |=> !clockRequest)
      else $error("clock still requested");
   a_pd_pause: assert property (clkEn && sleepPowerDown
      && state_reg == adcsq_pkg::ST_CONV |=> $stable(tickCnt_reg))
      else $error("conversion advanced in power-down");
   a_result_load: assert property (clkEn && done |=> result_reg == $past(adcData))
      else $error("result not loaded with flag");
   a_single_req: assert property (clkEn && active && request_reg && swStart && !done && !tick
      |=> request_reg && $stable(state_reg))
      else $error("retrigger disturbed conversion");
endmodule : adcsq_top

// *** tb/adcsq_event_src.sv ***
// Purpose: model of the event routing network feeding start events
// Assumes: events are levels synchronous to sys_clk
// Notes: pulse width per call, fast or slow
`timescale 1ns/1ps
module adcsq_event_src (
   // clock
   input wire logic sys_clk,
   // event out
   output logic eventStart
);
   initial eventStart = 1'b0;
   // high for width cycles, then low for at least one sample
   task automatic pulse(input int width);
      @(posedge sys_clk);
      eventStart <= 1'b1;
      repeat (width) @(posedge sys_clk);
      eventStart <= 1'b0;
      @(posedge sys_clk);
   endtask : pulse
endmodule : adcsq_event_src

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the conversion sequencer
// Assumes: register port with one-cycle strobes, read data next cycle
// Notes: initial delay set in the standby scenario, window flag follows windowHit
`timescale 1ns/1ps
module tb_top;
   logic sys_clk;
   logic sys_rst;
   logic clkEn;
   logic [3:0] regAddr;
   logic [7:0] regWrData;
   logic regWr;
   logic regRd;
   logic [7:0] regRdData;
   logic eventStart;
   logic sleepStandby;
   logic sleepPowerDown;
   logic [9:0] adcData;
   logic windowHit;
   logic convBusy;
   logic irq;
   logic [7:0] irqVector;
   logic clockRequest;
   int errCount;
   int comparisons;
   int n;

   adcsq_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .eventStart(eventStart), .sleepStandby(sleepStandby), .sleepPowerDown(sleepPowerDown),
      .adcData(adcData), .windowHit(windowHit), .convBusy(convBusy), .irq(irq),
      .irqVector(irqVector), .clockRequest(clockRequest));
   adcsq_event_src ev (.sys_clk(sys_clk), .eventStart(eventStart));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      if (errCount == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rdChk(input string name, input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      chk(name, {8'h00, e}, {8'h00, regRdData});
   endtask : rdChk

   task automatic waitLevel(input logic lvl, output int k);
      k = 0;
      while (convBusy !== lvl && k < 5000) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      chk("busy level", {15'h0000, lvl}, {15'h0000, convBusy});
   endtask : waitLevel

   task automatic waitDone;
      waitLevel(1'b1, n);
      waitLevel(1'b0, n);
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : waitDone

   task automatic idleCycles(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : idleCycles

   task automatic tReset;
      rdChk("ctrl", adcsq_pkg::OFF_CTRL, 8'h00);
      rdChk("flags", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h00);
      rdChk("unmapped", 4'h9, 8'h00);
      chk("irq", 16'h0000, {15'h0000, irq});
   endtask : tReset

   task automatic tDelay;
      logic [9:0] d;
      wr(adcsq_pkg::OFF_CTRL, 8'h01);
      for (int s = 0; s < 8; s++) begin
         d = 10'h2A5 ^ 10'(s);
         @(posedge sys_clk);
         adcData <= d;
         wr(adcsq_pkg::OFF_CLOCK_DIVIDER_SELECT, 8'(s));
         wr(adcsq_pkg::OFF_COMMAND, 8'h01);
         waitLevel(1'b1, n);
         chk("start delay", 16'((1 << s) + 2), 16'(n));
         waitDone();
         chk("irq off", 16'h0000, {15'h0000, irq});
         rdChk("flag set", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
         rdChk("res lo", adcsq_pkg::OFF_RESLO, d[7:0]);
         rdChk("res hi", adcsq_pkg::OFF_RESHI, {6'h00, d[9:8]});
         rdChk("request", adcsq_pkg::OFF_COMMAND, 8'h00);
         wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
         rdChk("flag clr", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h00);
      end
      wr(adcsq_pkg::OFF_CLOCK_DIVIDER_SELECT, 8'h00);
   endtask : tDelay

   task automatic tIrq;
      wr(adcsq_pkg::OFF_INTEN, 8'h03);
      windowHit <= 1'b1;
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      waitDone();
      chk("irq on", 16'h0001, {15'h0000, irq});
      chk("vec result", 16'h0000, {8'h00, irqVector});
      wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      idleCycles(3);
      chk("irq window", 16'h0001, {15'h0000, irq});
      chk("vec window", 16'h0002, {8'h00, irqVector});
      wr(adcsq_pkg::OFF_INTEN, 8'h00);
      idleCycles(3);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      rdChk("win flag", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h02);
      wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h02);
      windowHit <= 1'b0;
   endtask : tIrq

   task automatic tEvent;
      wr(adcsq_pkg::OFF_EVCTRL, 8'h01);
      ev.pulse(1);
      rdChk("ev request", adcsq_pkg::OFF_COMMAND, 8'h01);
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      ev.pulse(3);
      waitDone();
      idleCycles(12);
      chk("ev ignored", 16'h0000, {15'h0000, convBusy});
      rdChk("ev flag", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      wr(adcsq_pkg::OFF_EVCTRL, 8'h00);
      ev.pulse(2);
      idleCycles(8);
      chk("ev off", 16'h0000, {15'h0000, convBusy});
   endtask : tEvent

   task automatic tFreeRun;
      wr(adcsq_pkg::OFF_CTRL, 8'h03);
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      waitLevel(1'b1, n);
      idleCycles(30);
      chk("rerun", 16'h0001, {15'h0000, convBusy});
      rdChk("fr flag", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      wr(adcsq_pkg::OFF_CTRL, 8'h01);
      waitDone();
      idleCycles(12);
      chk("fr stop", 16'h0000, {15'h0000, convBusy});
      wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      wr(adcsq_pkg::OFF_CTRL, 8'h00);
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      idleCycles(10);
      chk("disabled", 16'h0000, {15'h0000, convBusy});
   endtask : tFreeRun

   task automatic tSleep;
      wr(adcsq_pkg::OFF_CTRL, 8'h01);
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      waitLevel(1'b1, n);
      @(posedge sys_clk);
      sleepStandby <= 1'b1;
      idleCycles(4);
      chk("sb abort", 16'h0000, {15'h0000, convBusy});
      chk("sb clkreq", 16'h0000, {15'h0000, clockRequest});
      @(posedge sys_clk);
      sleepStandby <= 1'b0;
      rdChk("sb request", adcsq_pkg::OFF_COMMAND, 8'h00);
      wr(adcsq_pkg::OFF_INITDELAY, 8'h02);
      wr(adcsq_pkg::OFF_CTRL, 8'h05);
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      sleepStandby <= 1'b1;
      waitLevel(1'b1, n);
      chk("init delay", 16'h0007, 16'(n));
      chk("sb clk on", 16'h0001, {15'h0000, clockRequest});
      waitDone();
      chk("sb clk off", 16'h0000, {15'h0000, clockRequest});
      @(posedge sys_clk);
      sleepStandby <= 1'b0;
      rdChk("sb flag", adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      wr(adcsq_pkg::OFF_INTEN, 8'h01);
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      waitLevel(1'b1, n);
      @(posedge sys_clk);
      sleepPowerDown <= 1'b1;
      idleCycles(100);
      chk("pd paused", 16'h0001, {15'h0000, convBusy});
      chk("pd no irq", 16'h0000, {15'h0000, irq});
      @(posedge sys_clk);
      sleepPowerDown <= 1'b0;
      waitDone();
      chk("pd irq", 16'h0001, {15'h0000, irq});
      rdChk("pd invalid", adcsq_pkg::OFF_COMMAND, 8'h02);
      wr(adcsq_pkg::OFF_INTERRUPT_FLAGS_REG, 8'h01);
      sleepPowerDown <= 1'b1;
      wr(adcsq_pkg::OFF_COMMAND, 8'h01);
      idleCycles(10);
      @(posedge sys_clk);
      sleepPowerDown <= 1'b0;
      idleCycles(10);
      chk("pd refuse", 16'h0000, {15'h0000, convBusy});
   endtask : tSleep

   initial begin
      repeat (60000) @(posedge sys_clk);
      errCount++;
      give_verdict();
   end

   initial begin
      errCount = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      clkEn = 1'b1;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      sleepStandby = 1'b0;
      sleepPowerDown = 1'b0;
      adcData = 10'h000;
      windowHit = 1'b0;
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      tReset();
      tDelay();
      tIrq();
      tEvent();
      tFreeRun();
      tSleep();
      give_verdict();
   end
endmodule : tb_top
